// >>> verilog/flcd_pkg.sv
// package: register map, field layout, timing constants and carrier types
package flcd_pkg;

   // -----------------
   // register byte offsets
   // -----------------
   localparam logic [7:0] REG_CFG   = 8'h00;
   localparam logic [7:0] REG_TIME  = 8'h04;
   localparam logic [7:0] REG_THR   = 8'h08;
   localparam logic [7:0] REG_STAT  = 8'h0c;
   localparam logic [7:0] REG_ALARM = 8'h10;
   localparam logic [7:0] REG_RECOV = 8'h14;

   // -----------------
   // field positions
   // -----------------
   localparam int CFG_DET_EN   = 0;
   localparam int CFG_OTC_EN   = 1;
   localparam int CFG_OTC_SW   = 2;
   localparam int CFG_TGL_EN   = 3;
   localparam int CFG_LIM_LSB  = 8;
   localparam int TIME_REC_LSB = 0;
   localparam int TIME_DET_LSB = 8;
   localparam int TIME_OTC_LSB = 16;
   localparam int THR_TRIP_LSB = 0;
   localparam int THR_REC_LSB  = 8;
   localparam int ALARM_TGL    = 0;
   localparam int RECOV_CUR_LSB = 0;
   localparam int RECOV_TEMP   = 4;

   // -----------------
   // reset values and writable masks
   // -----------------
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] TIME_RST  = 32'h0000_0000;
   localparam logic [31:0] THR_RST   = 32'h0000_0000;
   localparam logic [31:0] CFG_MASK  = 32'h0000_070f;
   localparam logic [31:0] TIME_MASK = 32'h00ff_ffff;
   localparam logic [31:0] THR_MASK  = 32'h0000_ffff;

   // -----------------
   // timing
   // -----------------
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned TICK_MS     = 100;
   localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W      = 24;
   localparam logic [3:0]  TICKS_PER_S = 4'ha;
   localparam logic [2:0]  RETRY_WIN_S = 3'h5;

   // -----------------
   // bus responses
   // -----------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -----------------
   // carriers
   // -----------------
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } flcd_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } flcd_axi_rsp_t;

   typedef struct packed {
      logic short_circuit_discharge;
      logic discharge_overcurrent_first;
      logic discharge_overcurrent_second;
      logic charge_overcurrent;
   } flcd_trip_t;

endpackage

// >>> verilog/flcd_top.sv
// protection logic: current retry latch, charge-pin detector, charge overtemperature
// Notes on behaviour
// RULE1: each current trip bumps the shared retry counter.
// RULE2: counter clears after 5 fault-free seconds past re-enable.
// RULE3: limit select 0,2,4,8,16,32,48,96; zero disables latch.
// RULE4: counter at limit latches and stops timed recovery.
// RULE5: recovery command with a current bit clears the counter.
// RULE6: detector used only while enabled.
// RULE7: raw detector state is readable.
// RULE8: debounced flag follows detector after stable detector time.
// RULE9: debounced change sets toggle alarm.
// RULE10: detector time 100 ms to 25.5 s, 100 ms steps.
// RULE11: alarm drives alert only when enabled.
// RULE12: writing one clears toggle alarm.
// RULE13: alert while pin below trip threshold.
// RULE14: 8-bit thresholds, step regulator over 359.
// RULE15: overtemperature evaluated only when enabled.
// RULE16: fault after alert persists programmed check intervals.
// RULE17: fault turns charge switch off if control enabled.
// RULE18: trip clears alert, sets safety status.
// RULE19: at or above recovery threshold, fault recovers.
// RULE20: zero recovery threshold needs temperature recovery command.
// RULE21: timed current recovery after 1..255 s; zero disables.
// RULE22: latched switch stays off.
// RULE23: counter saturates at limit, idle with limit zero.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
module flcd_top
   import flcd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // clock, reset, enable
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          clk_en,
   // register bus
   input  wire flcd_axi_req_t axi_req,
   output flcd_axi_rsp_t      axi_rsp,
   // protection inputs
   input  wire flcd_trip_t    current_trip,
   input  wire logic          check_strobe,
   input  wire logic          charge_pin_detect,
   input  wire logic          ts_below_trip,
   input  wire logic          ts_below_recovery,
   // protection outputs
   output logic               charge_switch_drive,
   output logic               discharge_switch_drive,
   output logic               alert_out,
   output logic [7:0]         otc_trip_threshold,
   output logic [7:0]         otc_recovery_threshold
);

   typedef struct packed {
      logic [31:0]       cfg;
      logic [31:0]       timing;
      logic [31:0]       thr;
      logic              alarm;
      logic              aw_full;
      logic [7:0]        aw_addr;
      logic              w_full;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              awrdy;
      logic              wrdy;
      logic              arrdy;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              det_s1;
      logic              det_s2;
      logic              tsb_s1;
      logic              tsb_s2;
      logic              tsr_s1;
      logic              tsr_s2;
      logic              det_last;
      logic              det_db;
      logic [8:0]        det_cnt;
      logic [TICK_W-1:0] tick_cnt;
      logic [3:0]        sec_sub;
      logic [6:0]        retry_cnt;
      logic              latched;
      logic              dsg_fault;
      logic              chg_fault;
      logic [7:0]        rec_cnt;
      logic              win_act;
      logic [2:0]        win_cnt;
      logic              otc_alert;
      logic              otc_safe;
      logic [7:0]        otc_cnt;
      logic              alert;
      logic [1:0]        sw_on;
   } flcd_state_t;

   flcd_state_t st_ff;
   flcd_state_t nxt_st;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] limit_of(input logic [2:0] sel);
      case (sel)
         3'h0:    limit_of = 7'h00;
         3'h1:    limit_of = 7'h02;
         3'h2:    limit_of = 7'h04;
         3'h3:    limit_of = 7'h08;
         3'h4:    limit_of = 7'h10;
         3'h5:    limit_of = 7'h20;
         3'h6:    limit_of = 7'h30;
         default: limit_of = 7'h60;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = data[8*i +: 8];
         end
      end
      merge = r & mask;
   endfunction

   function automatic logic known(input logic [7:0] a);
      known = (a == REG_CFG) || (a == REG_TIME) || (a == REG_THR) || (a == REG_STAT)
              || (a == REG_ALARM) || (a == REG_RECOV);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        do_wr;
      logic        tick;
      logic        sec;
      logic        any_trip;
      logic        cur_rec;
      logic        tmp_rec;
      logic        tgl_clr;
      logic        tgl_set;
      logic [6:0]  lim;
      logic [2:0]  lim_sel;
      logic [7:0]  rec_s;
      logic [7:0]  det_t;
      logic [7:0]  otc_d;
      logic [7:0]  rd_addr;
      logic [31:0] rd;
      do_wr    = 1'b0;
      tick     = 1'b0;
      sec      = 1'b0;
      cur_rec  = 1'b0;
      tmp_rec  = 1'b0;
      tgl_clr  = 1'b0;
      tgl_set  = 1'b0;
      rd       = 32'h0000_0000;
      nxt_st   = st_ff;
      lim_sel  = st_ff.cfg[CFG_LIM_LSB +: 3];
      lim      = limit_of(lim_sel); // RULE3
      rec_s    = st_ff.timing[TIME_REC_LSB +: 8];
      det_t    = st_ff.timing[TIME_DET_LSB +: 8];
      otc_d    = st_ff.timing[TIME_OTC_LSB +: 8];
      rd_addr  = {axi_req.araddr[7:2], 2'h0};
      any_trip = |current_trip;

      // -------------------------------------------------------------
      // input synchronisers
      // -------------------------------------------------------------
      nxt_st.det_s1 = charge_pin_detect;
      nxt_st.det_s2 = st_ff.det_s1;
      nxt_st.tsb_s1 = ts_below_trip;
      nxt_st.tsb_s2 = st_ff.tsb_s1;
      nxt_st.tsr_s1 = ts_below_recovery;
      nxt_st.tsr_s2 = st_ff.tsr_s1;

      // -------------------------------------------------------------
      // register bus slave
      // -------------------------------------------------------------
      if (axi_req.awvalid && st_ff.awrdy) begin
         nxt_st.aw_full = 1'b1;
         nxt_st.aw_addr = {axi_req.awaddr[7:2], 2'h0};
      end
      if (axi_req.wvalid && st_ff.wrdy) begin
         nxt_st.w_full = 1'b1;
         nxt_st.w_data = axi_req.wdata;
         nxt_st.w_strb = axi_req.wstrb;
      end
      if (st_ff.bvalid && axi_req.bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_full && st_ff.w_full && !st_ff.bvalid) begin
         do_wr          = 1'b1;
         nxt_st.aw_full = 1'b0;
         nxt_st.w_full  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = known(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (do_wr) begin
         case (st_ff.aw_addr)
            REG_CFG:   nxt_st.cfg = merge(st_ff.cfg, st_ff.w_data, st_ff.w_strb, CFG_MASK);
            REG_TIME:  nxt_st.timing = merge(st_ff.timing, st_ff.w_data, st_ff.w_strb,
                                             TIME_MASK);
            REG_THR:   nxt_st.thr = merge(st_ff.thr, st_ff.w_data, st_ff.w_strb, THR_MASK);
            REG_ALARM: tgl_clr = st_ff.w_strb[0] && st_ff.w_data[ALARM_TGL]; // RULE12
            REG_RECOV: begin
               cur_rec = st_ff.w_strb[0] && (|st_ff.w_data[RECOV_CUR_LSB +: 4]);
               tmp_rec = st_ff.w_strb[0] && st_ff.w_data[RECOV_TEMP];
            end
            default: ;
         endcase
      end
      if (st_ff.rvalid && axi_req.rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (axi_req.arvalid && st_ff.arrdy) begin
         case (rd_addr)
            REG_CFG:   rd = st_ff.cfg;
            REG_TIME:  rd = st_ff.timing;
            REG_THR:   rd = st_ff.thr;
            REG_STAT:  rd = {16'h0000, 1'b0, st_ff.retry_cnt, 1'b0, st_ff.chg_fault,
                             st_ff.dsg_fault, st_ff.otc_safe, st_ff.otc_alert, st_ff.latched,
                             st_ff.det_db, st_ff.det_s2 & st_ff.cfg[CFG_DET_EN]}; // RULE7
            REG_ALARM: rd = {31'h0000_0000, st_ff.alarm};
            default:   rd = 32'h0000_0000;
         endcase
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd;
         nxt_st.rresp  = (known(rd_addr) && rd_addr != REG_RECOV) ? RESP_OKAY : RESP_SLVERR;
      end

      // -------------------------------------------------------------
      // 100 ms and one second timebase
      // -------------------------------------------------------------
      if (st_ff.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         nxt_st.tick_cnt = '0;
         tick            = 1'b1; // RULE10
      end else begin
         nxt_st.tick_cnt = st_ff.tick_cnt + TICK_W'(1);
      end
      if (tick) begin
         if (st_ff.sec_sub == TICKS_PER_S - 4'h1) begin
            nxt_st.sec_sub = 4'h0;
            sec            = 1'b1;
         end else begin
            nxt_st.sec_sub = st_ff.sec_sub + 4'h1;
         end
      end

      // -------------------------------------------------------------
      // current retry latch
      // -------------------------------------------------------------
      if (sec && st_ff.win_act) begin
         if (st_ff.win_cnt == RETRY_WIN_S - 3'h1) begin
            nxt_st.win_act   = 1'b0;
            nxt_st.retry_cnt = 7'h00; // RULE2
         end else begin
            nxt_st.win_cnt = st_ff.win_cnt + 3'h1;
         end
      end
      // timed recovery, held off while latched
      if ((st_ff.dsg_fault || st_ff.chg_fault) && rec_s != 8'h00 && !st_ff.latched) begin // RULE21 RULE22
         if (sec) begin
            if (st_ff.rec_cnt + 8'h01 >= rec_s) begin
               nxt_st.dsg_fault = 1'b0;
               nxt_st.chg_fault = 1'b0;
               nxt_st.rec_cnt   = 8'h00;
               nxt_st.win_act   = 1'b1;
               nxt_st.win_cnt   = 3'h0;
            end else begin
               nxt_st.rec_cnt = st_ff.rec_cnt + 8'h01;
            end
         end
      end else begin
         nxt_st.rec_cnt = 8'h00;
      end
      if (cur_rec) begin
         nxt_st.retry_cnt = 7'h00; // RULE5
         nxt_st.latched   = 1'b0;
         nxt_st.dsg_fault = 1'b0;
         nxt_st.chg_fault = 1'b0;
         nxt_st.rec_cnt   = 8'h00;
      end
      // a trip in the same cycle as a recovery command still counts
      if (any_trip) begin
         nxt_st.win_act = 1'b0;
         nxt_st.rec_cnt = 8'h00;
         if (current_trip.short_circuit_discharge || current_trip.discharge_overcurrent_first
             || current_trip.discharge_overcurrent_second) begin
            nxt_st.dsg_fault = 1'b1;
         end
         if (current_trip.charge_overcurrent) begin
            nxt_st.chg_fault = 1'b1;
         end
         if (lim != 7'h00) begin // RULE23
            if (nxt_st.retry_cnt < lim) begin
               nxt_st.retry_cnt = nxt_st.retry_cnt + 7'h01; // RULE1
            end
            if (nxt_st.retry_cnt >= lim) begin
               nxt_st.latched = 1'b1; // RULE4
            end
         end
      end

      // -------------------------------------------------------------
      // charge-pin detector debounce
      // -------------------------------------------------------------
      if (st_ff.cfg[CFG_DET_EN]) begin // RULE6
         if (st_ff.det_s2 != st_ff.det_last) begin
            nxt_st.det_last = st_ff.det_s2;
            nxt_st.det_cnt  = 9'h000;
         end else if (tick && st_ff.det_cnt <= {1'b0, det_t}) begin
            nxt_st.det_cnt = st_ff.det_cnt + 9'h001;
            // stable for more than the programmed number of 100 ms steps
            if (st_ff.det_cnt == {1'b0, det_t} && st_ff.det_db != st_ff.det_last) begin
               nxt_st.det_db = st_ff.det_last; // RULE8
               tgl_set       = 1'b1; // RULE9
            end
         end
      end
      // set wins over a simultaneous clear
      nxt_st.alarm = tgl_set || (st_ff.alarm && !tgl_clr); // RULE12
      nxt_st.alert = nxt_st.alarm && st_ff.cfg[CFG_TGL_EN]; // RULE11

      // -------------------------------------------------------------
      // charge overtemperature
      // -------------------------------------------------------------
      // command first, so a trip in the same cycle wins
      if (tmp_rec) begin
         nxt_st.otc_safe = 1'b0; // RULE20
         nxt_st.otc_cnt  = 8'h00;
      end
      if (!st_ff.cfg[CFG_OTC_EN]) begin // RULE15
         nxt_st.otc_alert = 1'b0;
         nxt_st.otc_cnt   = 8'h00;
      end else if (check_strobe) begin
         if (!st_ff.otc_safe) begin
            if (st_ff.tsb_s2) begin
               nxt_st.otc_alert = 1'b1; // RULE13
               if (st_ff.otc_cnt >= otc_d) begin // RULE16
                  nxt_st.otc_alert = 1'b0; // RULE18
                  nxt_st.otc_safe  = 1'b1;
                  nxt_st.otc_cnt   = 8'h00;
               end else begin
                  nxt_st.otc_cnt = st_ff.otc_cnt + 8'h01;
               end
            end else begin
               nxt_st.otc_alert = 1'b0; // RULE13
               nxt_st.otc_cnt   = 8'h00;
            end
         end else if (st_ff.thr[THR_REC_LSB +: 8] != 8'h00 && !st_ff.tsr_s2) begin // RULE20
            nxt_st.otc_safe = 1'b0; // RULE19
         end
      end

      // -------------------------------------------------------------
      // bus ready flags follow the buffer state
      // -------------------------------------------------------------
      nxt_st.awrdy = !nxt_st.aw_full && !nxt_st.bvalid;
      nxt_st.wrdy  = !nxt_st.w_full && !nxt_st.bvalid;
      nxt_st.arrdy = !nxt_st.rvalid;
      nxt_st.sw_on = {!nxt_st.chg_fault && !(nxt_st.otc_safe && nxt_st.cfg[CFG_OTC_SW]),
                      !nxt_st.dsg_fault}; // RULE17
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff        <= '0;
         st_ff.cfg    <= CFG_RST;
         st_ff.timing <= TIME_RST;
         st_ff.thr    <= THR_RST;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from state flops
   // ----------------------------------------------------------------
   assign axi_rsp.awready        = st_ff.awrdy;
   assign axi_rsp.wready         = st_ff.wrdy;
   assign axi_rsp.bvalid         = st_ff.bvalid;
   assign axi_rsp.bresp          = st_ff.bresp;
   assign axi_rsp.arready        = st_ff.arrdy;
   assign axi_rsp.rvalid         = st_ff.rvalid;
   assign axi_rsp.rdata          = st_ff.rdata;
   assign axi_rsp.rresp          = st_ff.rresp;
   assign alert_out              = st_ff.alert;
   assign otc_trip_threshold     = st_ff.thr[THR_TRIP_LSB +: 8]; // RULE14
   assign otc_recovery_threshold = st_ff.thr[THR_REC_LSB +: 8];
   assign discharge_switch_drive = st_ff.sw_on[0];
   assign charge_switch_drive    = st_ff.sw_on[1]; // RULE17

endmodule

// >>> verif/flcd_top_props.sv
// checker: bus, trip and register-effect properties of the protection block
module flcd_top_props
   import flcd_pkg::*;
(
   // clock, reset, enable
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          clk_en,
   // bus and trips
   input wire flcd_axi_req_t axi_req,
   input wire flcd_axi_rsp_t axi_rsp,
   input wire flcd_trip_t    current_trip,
   // outputs
   input wire logic          charge_switch_drive,
   input wire logic          discharge_switch_drive,
   input wire logic          alert_out,
   input wire logic [7:0]    otc_trip_threshold,
   input wire logic [7:0]    otc_recovery_threshold
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_dsg_off;
      clk_en && (current_trip[3:1] != 3'h0) |=> !discharge_switch_drive;
   endproperty
   a_dsg_off: assert property (p_dsg_off) else $error("discharge on after trip");
   property p_chg_off;
      clk_en && current_trip.charge_overcurrent |=> !charge_switch_drive;
   endproperty
   a_chg_off: assert property (p_chg_off) else $error("charge on after trip");
   property p_thr;
      $changed({otc_trip_threshold, otc_recovery_threshold}) && $past(aresetn)
         |-> axi_rsp.bvalid || $past(axi_rsp.bvalid);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold moved without write");
   property p_alert;
      $fell(alert_out) && $past(aresetn) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid);
   endproperty
   a_alert: assert property (p_alert) else $error("alert fell without write");
   property p_wref;
      axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
   endproperty
   a_wref: assert property (p_wref) else $error("write taken while answering");
   property p_rref;
      axi_rsp.rvalid |-> !axi_rsp.arready;
   endproperty
   a_rref: assert property (p_rref) else $error("read taken while answering");
   property p_unmap;
      clk_en && axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h18
         |=> axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read answer wrong");
   property p_bdone;
      clk_en && axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write answer stuck");
   c_read: cover property (axi_rsp.rvalid && axi_req.rready);
   c_chg: cover property ($fell(charge_switch_drive));
   c_alert: cover property ($rose(alert_out));
endmodule

// >>> verif/flcd_host.sv
// host model: register master on the block's bus
module flcd_host
   import flcd_pkg::*;
(
   // clock
   input  wire logic          aclk,
   // bus
   output flcd_axi_req_t      axi_req,
   input  wire flcd_axi_rsp_t axi_rsp
);
   initial axi_req = '0;

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      bit aw = 1'b0;
      bit w = 1'b0;
      @(posedge aclk);
      axi_req.awaddr <= a;
      axi_req.wdata <= v;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && axi_rsp.awready) begin
            aw = 1'b1;
            axi_req.awvalid <= 1'b0;
         end
         if (!w && axi_rsp.wready) begin
            w = 1'b1;
            axi_req.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!axi_rsp.bvalid);
      r = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do @(posedge aclk); while (!axi_rsp.arready);
      axi_req.arvalid <= 1'b0;
      do @(posedge aclk); while (!axi_rsp.rvalid);
      v = axi_rsp.rdata;
      r = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask
endmodule

// >>> verif/test_fault_latch_chg_detect_otc.sv
// testbench: registers, retry latch, detector and overtemperature sequences
module test_fault_latch_chg_detect_otc
   import flcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CNT = 32'h0000_7f04;
   logic aclk, aresetn = 1'b0, clk_en = 1'b1, check_strobe = 1'b0, charge_pin_detect = 1'b0;
   logic ts_below_trip = 1'b0, ts_below_recovery = 1'b0;
   logic charge_switch_drive, discharge_switch_drive, alert_out;
   logic [7:0] otc_trip_threshold, otc_recovery_threshold;
   flcd_axi_req_t axi_req;
   flcd_axi_rsp_t axi_rsp;
   flcd_trip_t current_trip = '0;
   int fails = 0, n_compared = 0, cyc = 0;
   logic [31:0] d;
   logic [1:0] r;

   flcd_top #(.TICK_CYCLES(10)) u_flcd_top (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .current_trip(current_trip),
      .check_strobe(check_strobe), .charge_pin_detect(charge_pin_detect),
      .ts_below_trip(ts_below_trip), .ts_below_recovery(ts_below_recovery),
      .charge_switch_drive(charge_switch_drive), .discharge_switch_drive(discharge_switch_drive),
      .alert_out(alert_out), .otc_trip_threshold(otc_trip_threshold),
      .otc_recovery_threshold(otc_recovery_threshold));
   flcd_host u_flcd_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input string nm);
      u_flcd_host.rd(a, d, r);
      chk(nm, d & m, e);
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] v);
      u_flcd_host.wr(a, v, r);
   endtask
   task automatic trip(input flcd_trip_t t);
      @(posedge aclk);
      current_trip <= t;
      @(posedge aclk);
      current_trip <= '0;
   endtask
   task automatic strb(input int n);
      repeat (n) begin
         @(posedge aclk);
         check_strobe <= 1'b1;
         @(posedge aclk);
         check_strobe <= 1'b0;
      end
   endtask
   // second-tick alignment adds up to a second
   task automatic dsg_back();
      for (int i = 0; i < 400 && discharge_switch_drive !== 1'b1; i++) @(posedge aclk);
      chk("dsg back", 32'(discharge_switch_drive), 32'h1);
   endtask
   task automatic ts(input logic v);
      ts_below_trip <= v;
      ts_below_recovery <= v;
      repeat (4) @(posedge aclk);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(REG_CFG, '1, CFG_RST, "cfg");
      rdc(REG_TIME, '1, TIME_RST, "time");
      rdc(REG_THR, '1, THR_RST, "thr");
      wrc(REG_CFG, '1);
      rdc(REG_CFG, '1, CFG_MASK, "cfg bits");
      wrc(REG_TIME, '1);
      rdc(REG_TIME, '1, TIME_MASK, "time bits");
      u_flcd_host.rd(8'h18, d, r);
      chk("unmapped", 32'(r), 32'(RESP_SLVERR));
      $display("registers done");
      wrc(REG_CFG, 32'h0);
      wrc(REG_TIME, 32'h0000_0101);
      trip(4'h8);
      rdc(REG_STAT, CNT, 32'h0, "limit zero");
      dsg_back();
      wrc(REG_CFG, 32'h0100);
      trip(4'h8);
      rdc(REG_STAT, CNT, 32'h0100, "count one");
      dsg_back();
      repeat (800) @(posedge aclk);
      rdc(REG_STAT, CNT, 32'h0, "window");
      trip(4'h8);
      dsg_back();
      trip(4'h1);
      rdc(REG_STAT, CNT, 32'h0204, "latched");
      repeat (300) @(posedge aclk);
      chk("chg held", 32'(charge_switch_drive), 32'h0);
      trip(4'h4);
      rdc(REG_STAT, CNT, 32'h0204, "saturate");
      wrc(REG_RECOV, 32'h1);
      rdc(REG_STAT, CNT, 32'h0, "recover cmd");
      chk("chg on", 32'(charge_switch_drive), 32'h1);
      $display("retry latch done");
      wrc(REG_CFG, 32'h9);
      charge_pin_detect <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(REG_STAT, 32'h3, 32'h1, "raw only");
      repeat (40) @(posedge aclk);
      rdc(REG_STAT, 32'h3, 32'h3, "debounced");
      rdc(REG_ALARM, 32'h1, 32'h1, "toggle");
      chk("alert", 32'(alert_out), 32'h1);
      wrc(REG_ALARM, 32'h1);
      rdc(REG_ALARM, 32'h1, 32'h0, "w1c");
      wrc(REG_CFG, 32'h1);
      charge_pin_detect <= 1'b0;
      repeat (40) @(posedge aclk);
      rdc(REG_ALARM, 32'h1, 32'h1, "toggle back");
      chk("masked", 32'(alert_out), 32'h0);
      charge_pin_detect <= 1'b1;
      wrc(REG_CFG, 32'h0);
      rdc(REG_STAT, 32'h1, 32'h0, "det off");
      $display("detector done");
      wrc(REG_THR, 32'h0040);
      chk("trip thr", 32'(otc_trip_threshold), 32'h40);
      wrc(REG_TIME, 32'h0002_0101);
      wrc(REG_CFG, 32'h6);
      ts(1'b1);
      strb(1);
      rdc(REG_STAT, 32'h18, 32'h08, "otc alert");
      strb(4);
      rdc(REG_STAT, 32'h18, 32'h10, "otc trip");
      chk("chg otc", 32'(charge_switch_drive), 32'h0);
      ts(1'b0);
      strb(2);
      rdc(REG_STAT, 32'h18, 32'h10, "no auto");
      wrc(REG_RECOV, 32'h10);
      rdc(REG_STAT, 32'h18, 32'h0, "temp cmd");
      wrc(REG_THR, 32'h3040);
      chk("rec thr", 32'(otc_recovery_threshold), 32'h30);
      ts(1'b1);
      strb(5);
      ts(1'b0);
      strb(1);
      rdc(REG_STAT, 32'h18, 32'h0, "auto rec");
      wrc(REG_CFG, 32'h4);
      ts(1'b1);
      strb(3);
      rdc(REG_STAT, 32'h18, 32'h0, "otc off");
      $display("overtemperature done");
      end_of_test();
   end
endmodule

bind flcd_top flcd_top_props u_flcd_top_props (.aclk(aclk),
   .aresetn(aresetn), .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .current_trip(current_trip), .charge_switch_drive(charge_switch_drive),
   .discharge_switch_drive(discharge_switch_drive), .alert_out(alert_out),
   .otc_trip_threshold(otc_trip_threshold), .otc_recovery_threshold(otc_recovery_threshold));
